// >>> include/hmpr_map.svh
/*
  register offsets, field positions, reset values and timing constants for the haptic register slice.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef HMPR_MAP_SVH
`define HMPR_MAP_SVH

`define HMPR_OFS_OL_PERIOD_HIGH 8'h2e
`define HMPR_OFS_OL_PERIOD_LOW 8'h2f
`define HMPR_OFS_IMP_COEFF 8'h30
`define HMPR_OFS_PTR_HIGH 8'hfd
`define HMPR_OFS_PTR_LOW 8'hfe
`define HMPR_OFS_MEM_DATA 8'hff

`define HMPR_OL_HIGH_MSB 1
`define HMPR_OL_PERIOD_RST 10'h0c6
`define HMPR_IMP_COEFF_RST 8'h00
`define HMPR_PTR_RST 16'h0000

// open-loop time unit in nanoseconds (24.615 us)
`define HMPR_OL_UNIT_NS 24615
`define HMPR_CLK_PERIOD_NS 10
// rounded down, the unit is the longest cycle count that fits inside it
`define HMPR_OL_UNIT_CYC (`HMPR_OL_UNIT_NS / `HMPR_CLK_PERIOD_NS)

`define HMPR_MEM_AW 16
`define HMPR_MEM_DW 8

`endif

// >>> include/hmpr_pkg.sv
/*
  types for the haptic register slice.
  assumes hmpr_map.svh is on the include path.
*/
`include "hmpr_map.svh"

package hmpr_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hmpr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } hmpr_rsp_t;

  typedef enum logic [1:0] {
    HMPR_IDLE,
    HMPR_MEM_WAIT,
    HMPR_ANSWER
  } hmpr_state_t;

endpackage : hmpr_pkg

// >>> hdl/hmpr_mem.sv
/*
  64 kbyte single-port waveform memory with registered read data.
  assumes one access per cycle; write and read never in the same cycle.
*/
`timescale 1ns/10ps

module hmpr_mem (
  // clock
  input wire logic i_mclk,
  input wire logic i_ce,
  // access
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [0:65535];
  logic [7:0] rdata_q;

  always_ff @(posedge i_mclk) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_ce && i_re) begin
      rdata_q <= mem[i_addr];
    end
  end

  assign o_rdata = rdata_q;

endmodule : hmpr_mem

// >>> hdl/hmpr_ol_timer.sv
/*
  open-loop drive period generator: toggles the drive phase every half period.
  assumes period is stable between edges; a change takes effect at the next unit boundary, within the current half period.
*/
`timescale 1ns/10ps
`include "hmpr_map.svh"

module hmpr_ol_timer (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // control
  input wire logic i_enable,
  input wire logic [9:0] i_period,
  // drive
  output logic o_phase
);
  import hmpr_pkg::*;

  // 12 bits hold the full unit count without truncation
  localparam logic [11:0] UNIT_CYC = 12'(`HMPR_OL_UNIT_CYC);

  logic [11:0] unit_q, unit_d;
  logic [9:0] half_q, half_d;
  logic phase_q, phase_d;

  always_comb begin
    unit_d = unit_q;
    half_d = half_q;
    phase_d = phase_q;
    if (!i_enable || i_period == 10'h000) begin
      unit_d = 12'h000;
      half_d = 10'h000;
      phase_d = 1'b0;
    end else if (unit_q == UNIT_CYC - 12'h001) begin
      unit_d = 12'h000;
      // half period in units is period/2 with bit 0 forced to one, so at least one
      if (half_q + 10'h001 >= ((i_period >> 1) | 10'h001)) begin
        half_d = 10'h000;
        phase_d = ~phase_q;
      end else begin
        half_d = half_q + 10'h001;
      end
    end else begin
      unit_d = unit_q + 12'h001;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      unit_q <= 12'h000;
      half_q <= 10'h000;
      phase_q <= 1'b0;
    end else if (i_ce) begin
      unit_q <= unit_d;
      half_q <= half_d;
      phase_q <= phase_d;
    end
  end

  assign o_phase = phase_q;

endmodule : hmpr_ol_timer

// >>> hdl/hmpr_regs.sv
/*
  haptic register slice: open-loop period, impedance coefficient and
  auto-incrementing indirect port to the waveform memory.
  assumes the i2c target front end delivers one-cycle read/write strobes,
  holds off further strobes until the read answer, and that the diagnostic
  engine pulses its coefficient update.
*/
`timescale 1ns/10ps
`include "hmpr_map.svh"

module hmpr_regs (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_ce,
  // register requests from the serial target
  input hmpr_pkg::hmpr_req_t i_req,
  output hmpr_pkg::hmpr_rsp_t o_rsp,
  // diagnostic engine
  input wire logic i_coeff_load,
  input wire logic [7:0] i_coeff,
  // open-loop drive
  input wire logic i_ol_enable,
  output logic o_ol_phase,
  output logic [9:0] o_ol_period
);
  import hmpr_pkg::*;

  hmpr_state_t state_q, state_d;
  logic [9:0] period_q, period_d;
  logic [7:0] coeff_q, coeff_d;
  logic [15:0] ptr_q, ptr_d;
  logic [7:0] rdata_q, rdata_d;
  logic valid_q, valid_d;
  logic mem_we, mem_re;
  logic [7:0] mem_rdata;
  logic ol_phase;

  function automatic logic [15:0] ptr_next(input logic [15:0] p);
    ptr_next = p + 16'h0001;
  endfunction : ptr_next

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [9:0] per,
                                          input logic [7:0] co, input logic [15:0] p);
    case (a)
      `HMPR_OFS_OL_PERIOD_HIGH: reg_read = {6'h00, per[9:8]};
      `HMPR_OFS_OL_PERIOD_LOW: reg_read = per[7:0];
      `HMPR_OFS_IMP_COEFF: reg_read = co;
      `HMPR_OFS_PTR_HIGH: reg_read = p[15:8];
      `HMPR_OFS_PTR_LOW: reg_read = p[7:0];
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  always_comb begin
    state_d = state_q;
    period_d = period_q;
    coeff_d = coeff_q;
    ptr_d = ptr_q;
    rdata_d = rdata_q;
    valid_d = 1'b0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    if (i_coeff_load) begin
      coeff_d = i_coeff;
    end
    case (state_q)
      HMPR_IDLE: begin
        if (i_req.wr) begin
          case (i_req.addr)
            `HMPR_OFS_OL_PERIOD_HIGH: period_d[9:8] = i_req.wdata[`HMPR_OL_HIGH_MSB:0];
            `HMPR_OFS_OL_PERIOD_LOW: period_d[7:0] = i_req.wdata;
            `HMPR_OFS_PTR_HIGH: ptr_d[15:8] = i_req.wdata;
            `HMPR_OFS_PTR_LOW: ptr_d[7:0] = i_req.wdata;
            `HMPR_OFS_MEM_DATA: begin
              mem_we = 1'b1;
              ptr_d = ptr_next(ptr_q);
            end
            default: begin
            end
          endcase
        end else if (i_req.rd) begin
          if (i_req.addr == `HMPR_OFS_MEM_DATA) begin
            mem_re = 1'b1;
            state_d = HMPR_MEM_WAIT;
          end else begin
            rdata_d = reg_read(i_req.addr, period_q, coeff_q, ptr_q);
            valid_d = 1'b1;
          end
        end
      end
      HMPR_MEM_WAIT: begin
        // memory data lands one cycle after the strobe
        rdata_d = mem_rdata;
        valid_d = 1'b1;
        ptr_d = ptr_next(ptr_q);
        state_d = HMPR_IDLE;
      end
      default: begin
        state_d = HMPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_q <= HMPR_IDLE;
      period_q <= `HMPR_OL_PERIOD_RST;
      coeff_q <= `HMPR_IMP_COEFF_RST;
      ptr_q <= `HMPR_PTR_RST;
      rdata_q <= 8'h00;
      valid_q <= 1'b0;
      o_ol_phase <= 1'b0;
      o_ol_period <= `HMPR_OL_PERIOD_RST;
    end else if (i_ce) begin
      state_q <= state_d;
      period_q <= period_d;
      coeff_q <= coeff_d;
      ptr_q <= ptr_d;
      rdata_q <= rdata_d;
      valid_q <= valid_d;
      o_ol_phase <= ol_phase;
      o_ol_period <= period_q;
    end
  end

  assign o_rsp.valid = valid_q;
  assign o_rsp.rdata = rdata_q;

  hmpr_mem u_mem (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .i_we(mem_we),
    .i_re(mem_re),
    .i_addr(ptr_q),
    .i_wdata(i_req.wdata),
    .o_rdata(mem_rdata)
  );

  hmpr_ol_timer u_timer (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_enable(i_ol_enable),
    .i_period(period_q),
    .o_phase(ol_phase)
  );

endmodule : hmpr_regs

// >>> test/hmpr_regs_asserts.sv
/* port checker for hmpr_regs.
   assumes i_ce held high. */
`timescale 1ns/10ps
module hmpr_regs_asserts (
  // clock and reset
  input logic i_mclk,
  input logic i_rstn,
  input logic i_ce,
  // design ports
  input hmpr_pkg::hmpr_req_t i_req,
  input hmpr_pkg::hmpr_rsp_t o_rsp,
  input logic i_coeff_load,
  input logic [7:0] i_coeff,
  input logic i_ol_enable,
  input logic o_ol_phase,
  input logic [9:0] o_ol_period
);
  import hmpr_pkg::*;
  logic [15:0] p_q;
  logic [7:0] k_q;
  logic [7:0] pl;
  logic rq;
  logic wq;
  assign pl = p_q[7:0];
  assign rq = i_req.rd && !i_req.wr;
  assign wq = i_req.wr;
  // shadow pointer and coefficient
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      p_q <= 16'h0000;
      k_q <= 8'h00;
    end else begin
      if (i_coeff_load)
        k_q <= i_coeff;
      if (wq && i_req.addr == 8'hfd)
        p_q[15:8] <= i_req.wdata;
      else if (wq && i_req.addr == 8'hfe)
        p_q[7:0] <= i_req.wdata;
      else if ((wq || rq) && i_req.addr == 8'hff)
        p_q <= p_q + 16'h0001;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  chk_valid_pulse: assert property (o_rsp.valid |=> !o_rsp.valid)
    else $error("valid too long");
  chk_reg_answer: assert property (rq && i_req.addr != 8'hff |=> o_rsp.valid)
    else $error("register answer late");
  chk_mem_answer: assert property (rq && i_req.addr == 8'hff |=> !o_rsp.valid ##1 o_rsp.valid)
    else $error("memory answer timing");
  chk_period_reset: assert property ($rose(i_rstn) |-> o_ol_period == 10'h0c6)
    else $error("period reset value");
  chk_period_low: assert property (wq && i_req.addr == 8'h2f |-> ##2 o_ol_period[7:0] == $past(i_req.wdata, 2))
    else $error("period low byte");
  chk_period_high: assert property (wq && i_req.addr == 8'h2e |->
    ##2 {6'h00, o_ol_period[9:8]} == ($past(i_req.wdata, 2) & 8'h03)) else $error("period high bits");
  chk_high_mask: assert property (rq && i_req.addr == 8'h2e |=> o_rsp.rdata[7:2] == 6'h00)
    else $error("reserved bits set");
  chk_coeff_read: assert property (rq && i_req.addr == 8'h30 |=> o_rsp.rdata == $past(k_q))
    else $error("coefficient value");
  chk_ptr_read: assert property (rq && i_req.addr == 8'hfe |=> o_rsp.rdata == $past(pl))
    else $error("pointer low byte");
endmodule : hmpr_regs_asserts
bind hmpr_regs hmpr_regs_asserts u_chk (.i_mclk, .i_rstn, .i_ce, .i_req, .o_rsp, .i_coeff_load,
  .i_coeff, .i_ol_enable, .o_ol_phase, .o_ol_period);

// >>> test/hmpr_host.sv
/* host model issuing register requests.
   assumes calls start 1 ns after a rising edge. */
`timescale 1ns/10ps
module hmpr_host (
  // clock
  input logic i_mclk,
  // register port
  output hmpr_pkg::hmpr_req_t o_req,
  input hmpr_pkg::hmpr_rsp_t i_rsp
);
  import hmpr_pkg::*;
  initial o_req = '0;
  // strobe left up so writes go back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_req = '{1'b1, 1'b0, a, d};
    @(posedge i_mclk);
    #1;
  endtask : wr
  // released lines inverted, never stale
  task automatic idle();
    o_req = '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
    @(posedge i_mclk);
    #1;
  endtask : idle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    o_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_mclk);
    #1;
    o_req = '{1'b0, 1'b0, ~a, 8'hff};
    n = 0;
    while (i_rsp.valid !== 1'b1 && n < 4) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    d = i_rsp.valid === 1'b1 ? i_rsp.rdata : 8'hxx;
    @(posedge i_mclk);
    #1;
  endtask : rd
endmodule : hmpr_host

// >>> test/tb_top.sv
/* self-checking bench for hmpr_regs.
   assumes the host model issues every request. */
`timescale 1ns/10ps
`include "hmpr_map.svh"
module tb_top;
  logic i_mclk = 1'b0;
  logic en = 1'b0;
  logic i_rstn = 1'b0;
  logic ld = 1'b0;
  logic [7:0] k = 8'h00;
  logic ph;
  logic [9:0] per;
  logic [7:0] d;
  int miscompares = 0;
  int comparisons = 0;
  hmpr_pkg::hmpr_req_t req;
  hmpr_pkg::hmpr_rsp_t rsp;
  initial forever #5 i_mclk = ~i_mclk;
  hmpr_host host (.i_mclk(i_mclk), .o_req(req), .i_rsp(rsp));
  hmpr_regs dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(1'b1), .i_req(req), .o_rsp(rsp),
    .i_coeff_load(ld), .i_coeff(k), .i_ol_enable(en), .o_ol_phase(ph), .o_ol_period(per));
  task automatic cchk(input string n, input int e, input int g);
    comparisons++;
    if (g != e) begin
      miscompares++;
      $display("[ERR] %s exp %0d got %0d", n, e, g);
    end
  endtask : cchk
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk($sformatf("reg %h", a), {2'h0, e}, {2'h0, d});
  endtask : rchk
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic t_reset();
    rchk(8'h2e, 8'h00);
    rchk(8'h2f, 8'hc6);
    rchk(8'h30, 8'h00);
    rchk(8'hfd, 8'h00);
    rchk(8'hfe, 8'h00);
    rchk(8'h31, 8'h00);
    chk("period", 10'h0c6, per);
    chk("phase", 10'h000, {9'h000, ph});
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs();
    host.wr(8'h2e, 8'hff);
    host.wr(8'h2f, 8'h5a);
    host.wr(8'h30, 8'h77);
    host.idle();
    rchk(8'h2e, 8'h03);
    rchk(8'h2f, 8'h5a);
    rchk(8'h30, 8'h00);
    chk("period", 10'h35a, per);
    ld = 1'b1;
    k = 8'ha5;
    @(posedge i_mclk);
    #1;
    ld = 1'b0;
    k = 8'h5a;
    rchk(8'h30, 8'ha5);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mem();
    host.wr(8'hfd, 8'hff);
    host.wr(8'hfe, 8'hfe);
    host.wr(8'hff, 8'h11);
    host.wr(8'hff, 8'h22);
    host.wr(8'hff, 8'h33);
    rchk(8'hfd, 8'h00);
    rchk(8'hfe, 8'h01);
    host.wr(8'hfe, 8'hfe);
    host.wr(8'hfd, 8'hff);
    host.idle();
    rchk(8'hff, 8'h11);
    rchk(8'hff, 8'h22);
    rchk(8'hff, 8'h33);
    host.wr(8'hfd, 8'h12);
    host.idle();
    rchk(8'hfd, 8'h12);
    rchk(8'hfe, 8'h01);
    $display("test mem done");
  endtask : t_mem
  // period 2 gives one unit per half period, then one output flop
  task automatic t_ol();
    int n;
    host.wr(8'h2e, 8'h00);
    host.wr(8'h2f, 8'h02);
    host.idle();
    en = 1'b1;
    n = 0;
    while (ph !== 1'b1 && n < 3000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    cchk("phase rise cycles", `HMPR_OL_UNIT_CYC + 1, n);
    en = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    chk("phase off", 10'h000, {9'h000, ph});
    $display("test open loop done");
  endtask : t_ol
  initial begin
    repeat (2) @(posedge i_mclk);
    #1;
    i_rstn = 1'b1;
    t_reset();
    t_regs();
    t_mem();
    t_ol();
    end_of_test();
  end
  // run needs about 2500 cycles
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule : tb_top
